// File: sfsr_pkg.sv
// package for the self-programming fuse/signature readback unit
// assumes a single 25 MHz ref_clk domain shared by cpu side and unit
package sfsr_pkg;
	localparam int CLK_HZ = 25000000;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam int BIT_SELFPROG_ENABLE = 0;
	localparam int BIT_PAGE_ERASE = 1;
	localparam int BIT_PAGE_WRITE = 2;
	localparam int BIT_LOCK_BIT_OPERATION = 3;
	localparam int BIT_RWW_READ_ENABLE = 4;
	localparam int BIT_SIGNATURE_READ = 5;
	localparam int LOAD_WINDOW = 3;
	localparam int STORE_WINDOW = 4;
	localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
	localparam logic [15:0] PTR_LOCK = 16'h0001;
	localparam logic [15:0] PTR_EXT_FUSE = 16'h0002;
	localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
	localparam logic [15:0] PTR_SIG_ID1 = 16'h0000;
	localparam logic [15:0] PTR_SIG_CAL = 16'h0001;
	localparam logic [15:0] PTR_SIG_ID2 = 16'h0002;
	localparam logic [15:0] PTR_SIG_ID3 = 16'h0004;
	localparam logic [15:0] PTR_SERIAL_FIRST = 16'h000e;
	localparam logic [15:0] PTR_SERIAL_LAST = 16'h0017;
	localparam logic [15:0] PTR_SERIAL_GAP = 16'h0014;
	localparam logic [7:0] LOCK_UNUSED_MASK = 8'hc0;
	localparam logic [7:0] EXT_FUSE_UNUSED_MASK = 8'hf8;
	// flash write time, microseconds
	localparam int WRITE_MIN_US = 3700;
	localparam int WRITE_MAX_US = 4500;
	// aim at the middle of the window so either bound has margin
	localparam int WRITE_CYCLES =
		((WRITE_MIN_US + WRITE_MAX_US) / 2) * (CLK_HZ / 1000000);
	typedef enum {SFSR_IDLE, SFSR_ARMED, SFSR_WRITING} sfsr_state_t;
endpackage : sfsr_pkg

// File: sfsr_if.sv
// cpu-to-unit carrier for control writes, store and load instructions
// assumes both ends clocked by the same ref_clk
`timescale 1ns/10ps
interface sfsr_if;
	logic ctrl_wr;
	logic [7:0] ctrl_wdata;
	logic [7:0] ctrl_rdata;
	logic store_exec;
	logic load_exec;
	logic [15:0] pointer;
	logic [7:0] load_data;
	logic load_valid;
	logic cpu_halt;
	modport device (input ctrl_wr, ctrl_wdata, store_exec, load_exec,
		pointer, output ctrl_rdata, load_data, load_valid, cpu_halt);
	modport cpu (output ctrl_wr, ctrl_wdata, store_exec, load_exec,
		pointer, input ctrl_rdata, load_data, load_valid, cpu_halt);
endinterface : sfsr_if

// File: sfsr_write_timer.sv
// oscillator-timed flash write duration counter
// assumes start is a one-cycle pulse; reset does not abort a running write
`timescale 1ns/10ps
module sfsr_write_timer #(
	parameter int CYCLES = sfsr_pkg::WRITE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic start,
	output logic busy
);
	import sfsr_pkg::*;
	if (CYCLES < 1 || CYCLES > 2**24 - 1) begin : g_bad_cycles
		$error("write timer count out of range");
	end
	typedef struct packed {
		logic [23:0] count;
		logic busy;
	} sfsr_tmr_t;
	sfsr_tmr_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		if (s_reg.busy) begin
			if (s_reg.count == 24'h000001)
				s_next.busy = 1'b0;
			s_next.count = s_reg.count - 24'h000001;
		end else if (start) begin
			s_next.busy = 1'b1;
			s_next.count = 24'(CYCLES);
		end
	end
	// reset lets a write in progress finish; an unknown busy at power-up
	// falls to the clearing branch so the timer still leaves reset
	always_ff @(posedge ref_clk) begin
		if (!reset || s_reg.busy)
			s_reg <= s_next;
		else
			s_reg <= '0;
	end
	assign busy = s_reg.busy;
endmodule : sfsr_write_timer

// File: sfsr_device.sv
// flash controller self-programming access unit, cpu-visible side
// assumes the cpu end drives strobes as one-cycle pulses on ref_clk
//
// Behaviour
// - eeprom write blocks all flash programming commands
// - eeprom write blocks fuse and lock reads
// - software checks eeprom busy before control write
// - pointer 1 with lock op reads lock byte
// - lock op auto-clears on read or timeout
// - cleared bits make loads return program memory
// - lock byte layout boot locks then memory locks
// - pointer 0 with lock op reads fuse low
// - pointer 3 reads full fuse high byte
// - pointer 2 reads extended fuse, three bits
// - programmed reads zero, unprogrammed reads one
// - signature read within three cycles returns byte
// - signature op auto-clears on read or timeout
// - id bytes and calibration at fixed addresses
// - serial bytes at 0x0e to 0x17, skipping 0x14
// - software avoids reserved signature addresses
// - reset does not abort a running write
// - write time from oscillator, 3.7 to 4.5 ms
// - software polls enable and masks interrupts
// - only no-read-while-write code fetched during writes
// - store must follow control write within four cycles
// - control register zero after reset; a write running through reset holds it until the write ends
`timescale 1ns/10ps
module sfsr_device #(
	parameter int WRITE_CYCLES = sfsr_pkg::WRITE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	sfsr_if.device bus,
	input wire logic eeprom_write_busy,
	input wire logic [7:0] lock_bits,
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] extended_fuse_byte,
	input wire logic [7:0] sig_id1,
	input wire logic [7:0] sig_id2,
	input wire logic [7:0] sig_id3,
	input wire logic [7:0] osc_cal,
	input wire logic [71:0] serial_number,
	input wire logic [7:0] prog_mem_data,
	input wire logic fetch_in_no_read_while_write_section,
	output logic fetch_blocked,
	output logic flash_write_start
);
	import sfsr_pkg::*;
	typedef struct packed {
		sfsr_state_t state;
		logic [7:0] ctrl;
		logic [2:0] age;
		logic [7:0] load_data;
		logic load_valid;
		logic halt;
		logic blocked;
		logic wstart;
		logic [1:0] ee_sync;
	} sfsr_dev_t;
	sfsr_dev_t s_reg, s_next;
	logic wbusy;
	logic ee_busy;
	logic [7:0] cfg_byte;
	logic [7:0] sig_byte;
	logic [7:0] serial_byte [0:9];
	logic lock_op;
	logic sig_op;
	logic prog_op;
	sfsr_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.ref_clk(ref_clk),
		.reset(reset),
		.start(s_reg.wstart),
		.busy(wbusy)
	);
	assign ee_busy = s_reg.ee_sync[1];
	assign lock_op = s_reg.ctrl[BIT_LOCK_BIT_OPERATION] &&
		s_reg.ctrl[BIT_SELFPROG_ENABLE];
	assign sig_op = s_reg.ctrl[BIT_SIGNATURE_READ] &&
		s_reg.ctrl[BIT_SELFPROG_ENABLE];
	assign prog_op = s_reg.ctrl[BIT_SELFPROG_ENABLE] &&
		(s_reg.ctrl[BIT_PAGE_ERASE] || s_reg.ctrl[BIT_PAGE_WRITE] ||
		s_reg.ctrl[BIT_LOCK_BIT_OPERATION]);
	// serial order 1,0,3,2,5,4 then gap then 6,7,8; slot 6 is the gap
	always_comb begin
		serial_byte[0] = serial_number[15:8];
		serial_byte[1] = serial_number[7:0];
		serial_byte[2] = serial_number[31:24];
		serial_byte[3] = serial_number[23:16];
		serial_byte[4] = serial_number[47:40];
		serial_byte[5] = serial_number[39:32];
		serial_byte[6] = 8'hff;
		serial_byte[7] = serial_number[55:48];
		serial_byte[8] = serial_number[63:56];
		serial_byte[9] = serial_number[71:64];
	end
	// fuse values pass as stored: programmed is 0, unprogrammed is 1
	always_comb begin
		case (bus.pointer)
			PTR_FUSE_LOW: cfg_byte = fuse_low_byte;
			PTR_LOCK: cfg_byte = lock_bits | LOCK_UNUSED_MASK;
			PTR_EXT_FUSE: cfg_byte =
				extended_fuse_byte | EXT_FUSE_UNUSED_MASK;
			PTR_FUSE_HIGH: cfg_byte = fuse_high_byte;
			default: cfg_byte = 8'hff;
		endcase
	end
	// reserved addresses return all ones
	always_comb begin
		if (bus.pointer == PTR_SIG_ID1)
			sig_byte = sig_id1;
		else if (bus.pointer == PTR_SIG_CAL)
			sig_byte = osc_cal;
		else if (bus.pointer == PTR_SIG_ID2)
			sig_byte = sig_id2;
		else if (bus.pointer == PTR_SIG_ID3)
			sig_byte = sig_id3;
		else if (bus.pointer >= PTR_SERIAL_FIRST &&
			bus.pointer <= PTR_SERIAL_LAST &&
			bus.pointer != PTR_SERIAL_GAP)
			sig_byte = serial_byte[4'(bus.pointer - PTR_SERIAL_FIRST)];
		else
			sig_byte = 8'hff;
	end
	always_comb begin
		s_next = s_reg;
		s_next.ee_sync = {s_reg.ee_sync[0], eeprom_write_busy};
		s_next.load_valid = 1'b0;
		s_next.wstart = 1'b0;
		s_next.blocked = (wbusy || s_reg.state == SFSR_WRITING) &&
			!fetch_in_no_read_while_write_section;
		s_next.halt = s_reg.state == SFSR_WRITING;
		if (bus.load_exec) begin
			s_next.load_valid = 1'b1;
			s_next.load_data = prog_mem_data;
		end
		case (s_reg.state)
			SFSR_IDLE: begin
				if (bus.ctrl_wr && bus.ctrl_wdata[BIT_SELFPROG_ENABLE]) begin
					// a control write under eeprom write is dropped
					if (!ee_busy) begin
						s_next.ctrl = bus.ctrl_wdata;
						s_next.age = 3'd0;
						s_next.state = SFSR_ARMED;
					end
				end else if (bus.ctrl_wr) begin
					s_next.ctrl = CTRL_RESET;
				end
			end
			SFSR_ARMED: begin
				s_next.age = s_reg.age + 3'd1;
				if ((lock_op || sig_op) && bus.load_exec &&
					32'(s_reg.age) < LOAD_WINDOW) begin
					s_next.load_data = sig_op ? sig_byte : cfg_byte;
					s_next.ctrl = CTRL_RESET;
					s_next.state = SFSR_IDLE;
				end else if (prog_op && bus.store_exec && !sig_op &&
					32'(s_reg.age) < STORE_WINDOW) begin
					s_next.wstart = 1'b1;
					s_next.state = SFSR_WRITING;
				end else if (sig_op && 32'(s_reg.age) >= LOAD_WINDOW - 1) begin
					s_next.ctrl = CTRL_RESET;
					s_next.state = SFSR_IDLE;
				end else if (32'(s_reg.age) >= STORE_WINDOW - 1) begin
					// lock op is held for a possible store, load use ends at three
					s_next.ctrl = CTRL_RESET;
					s_next.state = SFSR_IDLE;
				end
			end
			SFSR_WRITING: begin
				if (!wbusy && !s_reg.wstart) begin
					s_next.ctrl = CTRL_RESET;
					s_next.state = SFSR_IDLE;
				end
			end
			default: s_next.state = SFSR_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		// an unknown timer state at power-up takes the clearing branch
		if (!reset) begin
			s_reg <= s_next;
		end else if (wbusy) begin
			s_reg.ee_sync <= 2'b00;
		end else begin
			s_reg <= '0;
			s_reg.state <= SFSR_IDLE;
		end
	end
	assign bus.ctrl_rdata = s_reg.ctrl;
	assign bus.load_data = s_reg.load_data;
	assign bus.load_valid = s_reg.load_valid;
	assign bus.cpu_halt = s_reg.halt;
	assign fetch_blocked = s_reg.blocked;
	assign flash_write_start = s_reg.wstart;
endmodule : sfsr_device

// File: sfsr_cpu.sv
// cpu-side end: issues the timed control-write then load/store pair
// assumes user pulses cmd_go for one cycle while cmd_ready is high
`timescale 1ns/10ps
module sfsr_cpu (
	input wire logic ref_clk,
	input wire logic reset,
	sfsr_if.cpu bus,
	input wire logic eeprom_write_busy,
	input wire logic cmd_go,
	input wire logic [7:0] cmd_ctrl,
	input wire logic cmd_is_load,
	input wire logic [15:0] cmd_pointer,
	output logic cmd_ready,
	output logic [7:0] result,
	output logic result_valid
);
	import sfsr_pkg::*;
	typedef enum {SFSC_IDLE, SFSC_POLL, SFSC_WRITE, SFSC_ISSUE,
		SFSC_WAIT} sfsc_state_t;
	typedef struct packed {
		sfsc_state_t state;
		logic [7:0] ctrl;
		logic is_load;
		logic [15:0] ptr;
		logic wr;
		logic st;
		logic ld;
		logic [7:0] result;
		logic rvalid;
		logic [1:0] ee_sync;
	} sfsc_s_t;
	sfsc_s_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		s_next.ee_sync = {s_reg.ee_sync[0], eeprom_write_busy};
		s_next.wr = 1'b0;
		s_next.st = 1'b0;
		s_next.ld = 1'b0;
		s_next.rvalid = 1'b0;
		case (s_reg.state)
			SFSC_IDLE: if (cmd_go) begin
				s_next.ctrl = cmd_ctrl;
				s_next.is_load = cmd_is_load;
				s_next.ptr = cmd_pointer;
				s_next.state = SFSC_POLL;
			end
			// previous operation done and no eeprom write
			SFSC_POLL: if (!bus.ctrl_rdata[BIT_SELFPROG_ENABLE] &&
				!s_reg.ee_sync[1]) begin
				s_next.wr = 1'b1;
				s_next.state = SFSC_WRITE;
			end
			SFSC_WRITE: begin
				// issue next cycle: inside both three and four cycle windows
				s_next.st = !s_reg.is_load;
				s_next.ld = s_reg.is_load;
				s_next.state = s_reg.is_load ? SFSC_WAIT : SFSC_IDLE;
			end
			SFSC_WAIT: if (bus.load_valid) begin
				s_next.result = bus.load_data;
				s_next.rvalid = 1'b1;
				s_next.state = SFSC_IDLE;
			end
			default: s_next.state = SFSC_IDLE;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_reg <= '0;
			s_reg.state <= SFSC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end
	// honoured by caller: only defined signature addresses
	assign bus.ctrl_wr = s_reg.wr;
	assign bus.ctrl_wdata = s_reg.ctrl;
	assign bus.pointer = s_reg.ptr;
	assign bus.store_exec = s_reg.st;
	assign bus.load_exec = s_reg.ld;
	assign cmd_ready = s_reg.state == SFSC_IDLE;
	assign result = s_reg.result;
	assign result_valid = s_reg.rvalid;
endmodule : sfsr_cpu

// File: sfsr_assertions.sv
// timing checks on the carrier between cpu end and device end
// assumes one ref_clk domain and the synchronous active-high reset
`timescale 1ns/10ps
module sfsr_assertions #(
	parameter int WRITE_CYCLES = sfsr_pkg::WRITE_CYCLES
) (
	input logic ref_clk,
	input logic reset,
	input logic [7:0] ctrl_rdata,
	input logic store_exec,
	input logic load_exec,
	input logic load_valid,
	input logic cpu_halt
);
	import sfsr_pkg::*;
	int halt_cnt_reg;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// not cleared by reset: a write keeps running through it
	always_ff @(posedge ref_clk) begin
		halt_cnt_reg <= cpu_halt ? halt_cnt_reg + 1 : 0;
	end
	sequence s_sig_armed;
		$rose(ctrl_rdata[BIT_SIGNATURE_READ] & ctrl_rdata[0]);
	endsequence
	sequence s_lock_armed;
		$rose(ctrl_rdata == 8'h09);
	endsequence
	a_load_answer: assert property (load_exec |=> load_valid)
		else $error("load got no answer");
	a_valid_cause: assert property (load_valid |-> $past(load_exec))
		else $error("answer without load");
	a_sig_timeout: assert property (s_sig_armed |-> ##[1:3] !ctrl_rdata[0])
		else $error("signature op not cleared");
	a_lock_timeout: assert property (s_lock_armed |-> ##[1:4] !ctrl_rdata[0])
		else $error("lock op not cleared");
	a_read_clear: assert property (load_exec &&
		(ctrl_rdata == 8'h09 || ctrl_rdata == 8'h21) |=> ctrl_rdata == 8'h00)
		else $error("control bits kept after read");
	a_ctrl_reset: assert property (disable iff (1'b0)
		reset && !cpu_halt |=> ctrl_rdata == CTRL_RESET)
		else $error("control not zero after reset");
	a_halt_reset: assert property (disable iff (1'b0)
		cpu_halt && reset |=> cpu_halt)
		else $error("reset aborted write");
	a_halt_cause: assert property ($rose(cpu_halt) |-> $past(store_exec, 2))
		else $error("write without store");
	a_halt_min: assert property ($rose(cpu_halt) |-> cpu_halt[*8])
		else $error("write too short");
	a_halt_max: assert property (halt_cnt_reg <= WRITE_CYCLES + 4)
		else $error("write too long");
	a_sig_no_write: assert property (store_exec &&
		ctrl_rdata[BIT_SIGNATURE_READ] |-> ##2 !cpu_halt)
		else $error("store with signature op wrote");
endmodule : sfsr_assertions

// File: selfprog_fuse_sig_readback_tb_top.sv
// bench: cpu end and device end joined by the carrier
// assumes sfsr_pkg, sfsr_if and both ends compiled first
`timescale 1ns/10ps
module selfprog_fuse_sig_readback_tb_top;
	import sfsr_pkg::*;
	localparam int WC = 20;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic ee_dev = 1'b0;
	logic ee_cpu = 1'b0;
	logic no_read_while_write_section = 1'b0;
	logic cmd_go = 1'b0;
	logic [7:0] cmd_ctrl = 8'h00;
	logic cmd_is_load = 1'b0;
	logic [15:0] cmd_pointer = 16'h0000;
	logic cmd_ready, result_valid, fetch_blocked, flash_write_start;
	logic [7:0] result;
	logic [7:0] pm = 8'h5a;
	logic [7:0] cfg [0:7] = '{8'h12, 8'h5c, 8'h99, 8'h35, 8'h1e, 8'h94,
		8'h0a, 8'h7c};
	logic [71:0] serial = 72'h988776655443322110;
	int n_fail = 0;
	int compares = 0;
	int n_start = 0;
	// ctrl, pointer, expected byte; lock 7:6 and ext fuse 7:3 read as one
	logic [31:0] rows [0:18] = '{32'h090001d2, 32'h0900005c, 32'h090002fd,
		32'h09000399, 32'h2100001e, 32'h2100017c, 32'h21000294,
		32'h2100040a, 32'h21000e21, 32'h21000f10, 32'h21001043,
		32'h21001132, 32'h21001265, 32'h21001354, 32'h0000145a,
		32'h21001576, 32'h21001687, 32'h21001798, 32'h0000005a};
	sfsr_if bus ();
	sfsr_cpu sfsr_cpu_inst (.ref_clk(ref_clk), .reset(reset), .bus(bus),
		.eeprom_write_busy(ee_cpu), .cmd_go(cmd_go), .cmd_ctrl(cmd_ctrl),
		.cmd_is_load(cmd_is_load), .cmd_pointer(cmd_pointer),
		.cmd_ready(cmd_ready), .result(result), .result_valid(result_valid));
	sfsr_device #(.WRITE_CYCLES(WC)) sfsr_device_inst (.ref_clk(ref_clk),
		.reset(reset), .bus(bus), .eeprom_write_busy(ee_dev),
		.lock_bits(cfg[0]), .fuse_low_byte(cfg[1]), .fuse_high_byte(cfg[2]),
		.extended_fuse_byte(cfg[3]), .sig_id1(cfg[4]), .sig_id2(cfg[5]),
		.sig_id3(cfg[6]), .osc_cal(cfg[7]), .serial_number(serial),
		.prog_mem_data(pm), .fetch_in_no_read_while_write_section(no_read_while_write_section),
		.fetch_blocked(fetch_blocked), .flash_write_start(flash_write_start));
	sfsr_assertions #(.WRITE_CYCLES(WC)) sfsr_assertions_inst (
		.ref_clk(ref_clk), .reset(reset), .ctrl_rdata(bus.ctrl_rdata),
		.store_exec(bus.store_exec), .load_exec(bus.load_exec),
		.load_valid(bus.load_valid), .cpu_halt(bus.cpu_halt));
	always #20 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (flash_write_start === 1'b1) n_start++;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	task automatic do_cmd(input logic [7:0] c, input logic ld,
		input logic [15:0] p);
		int k;
		k = 0;
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1 && k < 200) begin
			@(negedge ref_clk);
			k++;
		end
		check(cmd_ready, 1'b1);
		cmd_go = 1'b1;
		cmd_ctrl = c;
		cmd_is_load = ld;
		cmd_pointer = p;
		@(negedge ref_clk);
		cmd_go = 1'b0;
	endtask : do_cmd
	task automatic fetch(input logic [7:0] exp);
		int k;
		k = 0;
		while (result_valid !== 1'b1 && k < 50) begin
			@(negedge ref_clk);
			k++;
		end
		check(result_valid, 1'b1);
		check(result, exp);
	endtask : fetch
	task automatic wr(input logic [7:0] c, input logic [7:0] starts);
		do_cmd(c, 1'b0, 16'h0000);
		repeat (6) @(negedge ref_clk);
		check(8'(n_start), starts);
	endtask : wr
	initial begin
		repeat (16) @(negedge ref_clk);
		reset = 1'b0;
		check(bus.ctrl_rdata, CTRL_RESET);
		check(bus.cpu_halt, 1'b0);
		foreach (rows[i]) begin
			do_cmd(rows[i][31:24], 1'b1, rows[i][23:8]);
			fetch(rows[i][7:0]);
		end
		// only the device end sees the eeprom busy here
		ee_dev = 1'b1;
		repeat (4) @(negedge ref_clk);
		do_cmd(8'h09, 1'b1, 16'h0001);
		fetch(pm);
		check(bus.ctrl_rdata, 8'h00);
		wr(8'h03, 8'h00);
		ee_dev = 1'b0;
		repeat (4) @(negedge ref_clk);
		wr(8'h21, 8'h00);
		ee_cpu = 1'b1;
		do_cmd(8'h09, 1'b1, 16'h0003);
		repeat (10) @(negedge ref_clk);
		check(bus.ctrl_rdata, 8'h00);
		ee_cpu = 1'b0;
		fetch(8'h99);
		wr(8'h03, 8'h01);
		check(bus.cpu_halt, 1'b1);
		check(fetch_blocked, 1'b1);
		no_read_while_write_section = 1'b1;
		@(negedge ref_clk);
		check(fetch_blocked, 1'b0);
		reset = 1'b1;
		@(negedge ref_clk);
		reset = 1'b0;
		check(bus.cpu_halt, 1'b1);
		repeat (WC) @(negedge ref_clk);
		check(bus.cpu_halt, 1'b0);
		check(bus.ctrl_rdata, 8'h00);
		do_cmd(8'h09, 1'b1, 16'h0000);
		fetch(8'h5c);
		test_done;
	end
	// whole run is well under 2000 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_fail++;
		$display("ERROR t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
		test_done;
	end
endmodule : selfprog_fuse_sig_readback_tb_top
